// file: fpes_map.svh
// Constants for the flash program and erase sequencer.
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH
`define FPES_CMD_LOCK 8'h00
`define FPES_CMD_UNLOCK1 8'h73
`define FPES_CMD_UNLOCK2 8'h8C
`define FPES_CMD_ERASE 8'h95
`define FPES_ERASED_WORD 16'hFFFF
`define FPES_PAGE_BYTES 2048
`define FPES_PAGE_LSB 11
`define FPES_ADDR_W 17
`define FPES_SECT_PAGES_LOG2 3
`define FPES_SECT_N 8
`endif

// file: fpes_pkg.sv
// Types shared by the flash program and erase sequencer.
package fpes_pkg;
  typedef enum logic [1:0] {
    LK_LOCKED,
    LK_HALF,
    LK_OPEN
  } fpes_lock_t;
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_READ,
    OP_MERGE,
    OP_PROG,
    OP_ERASE
  } fpes_op_t;
  typedef logic [15:0] fpes_word_t;
endpackage

// file: fpes_merge.sv
// Byte to word merge unit in front of the flash programmer.
`timescale 1ns/100ps
module fpes_merge #(
  parameter int WA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic wr,
  input wire logic [1:0] be,
  input wire logic [WA_W-1:0] waddr,
  input wire fpes_pkg::fpes_word_t wdata,
  input wire logic take,
  output logic vld,
  output logic [WA_W-1:0] vaddr,
  output fpes_pkg::fpes_word_t vdata
);
  import fpes_pkg::*;
  logic [1:0] have_r, have_nxt;
  logic [WA_W-1:0] addr_r, addr_nxt;
  fpes_word_t data_r, data_nxt;
  logic vld_r, vld_nxt;
  logic [1:0] base;

  // A lone byte waits for its partner byte of the same word.
  always_comb begin
    have_nxt = have_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    vld_nxt = vld_r;
    base = (addr_r == waddr) ? have_r : 2'h0;
    if (take) begin
      vld_nxt = 1'b0;
      have_nxt = 2'h0;
    end
    if (clr) begin
      vld_nxt = 1'b0;
      have_nxt = 2'h0;
    end else if (wr && !vld_r) begin
      addr_nxt = waddr;
      if (be[0]) begin
        data_nxt[7:0] = wdata[7:0];
      end
      if (be[1]) begin
        data_nxt[15:8] = wdata[15:8];
      end
      have_nxt = base | be;
      if ((base | be) == 2'h3) begin
        vld_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      have_r <= 2'h0;
      addr_r <= '0;
      data_r <= 16'h0000;
      vld_r <= 1'b0;
    end else begin
      have_r <= have_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign vld = vld_r;
  assign vaddr = addr_r;
  assign vdata = data_r;

  word_needs_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(vld_r) |-> $past(have_nxt) == 2'h3)
    else $error("word formed without both bytes");
endmodule // fpes_merge

// file: fpes_seq.sv
// Flash program and erase sequencer with two-step unlock.
// How it works
// - Unlocked in-page word writes get programmed.
// - Erased words read as all ones.
// - Programming only clears bits to zero.
// - Program whole words; await partner byte.
// - Stall flash reads while programming.
// - Defer interrupts until programming ends.
// - Command 00h locks and leaves programming.
// - Refuse pages inside protected sectors.
// - Ignore writes outside the unlocked page.
// - Page erase sets whole 2 KB page.
// - Erase targets the selected page.
// - Erase stalls reads and defers interrupts.
`timescale 1ns/100ps
`include "fpes_map.svh"
module fpes_seq #(
  parameter int ADDR_W = `FPES_ADDR_W,
  parameter int PAGE_LSB = `FPES_PAGE_LSB,
  parameter int SECT_N = `FPES_SECT_N
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CMD_WR,
  input wire logic [7:0] CMD_DATA,
  input wire logic PSEL_WR,
  input wire logic [7:0] PSEL_DATA,
  input wire logic MEM_WR,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic [1:0] MEM_BE,
  input wire fpes_pkg::fpes_word_t MEM_WDATA,
  input wire logic [SECT_N-1:0] SECT_PROT,
  input wire fpes_pkg::fpes_word_t FL_RDATA,
  input wire logic FL_DONE,
  output logic MEM_RDY,
  output logic FL_RD,
  output logic FL_PROG,
  output logic FL_ERASE,
  output logic [ADDR_W-2:0] FL_ADDR,
  output fpes_pkg::fpes_word_t FL_WDATA,
  output logic READ_WAIT,
  output logic IRQ_DEFER,
  output logic UNLOCKED,
  output logic [7:0] PAGE_SEL
);
  import fpes_pkg::*;
  localparam int PG_W = ADDR_W - PAGE_LSB;
  localparam int WA_W = ADDR_W - 1;

  fpes_lock_t lock_r, lock_nxt;
  fpes_op_t op_r, op_nxt;
  logic [7:0] psel_r, psel_nxt;
  logic [WA_W-1:0] fa_r, fa_nxt;
  fpes_word_t fd_r, fd_nxt;
  logic m_vld;
  logic [WA_W-1:0] m_addr;
  fpes_word_t m_data;
  logic take, clr, in_page, mem_ok, erase_go;

  function automatic logic [PG_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:PAGE_LSB];
  endfunction

  function automatic logic prot_hit(input logic [7:0] p,
                                    input logic [SECT_N-1:0] prot);
    logic [7:0] s;
    s = p >> `FPES_SECT_PAGES_LOG2;
    prot_hit = (s < 8'(SECT_N)) ? prot[s[$clog2(SECT_N)-1:0]] : 1'b0;
  endfunction

  assign in_page = page_of(MEM_ADDR) == psel_r[PG_W-1:0];
  assign mem_ok = (lock_r == LK_OPEN) && in_page
    && !prot_hit(psel_r, SECT_PROT);
  assign clr = (lock_r != LK_OPEN);
  assign erase_go = CMD_WR && (lock_r == LK_OPEN)
    && (CMD_DATA == `FPES_CMD_ERASE)
    && !prot_hit(psel_r, SECT_PROT);
  // A word ready in the same cycle as an erase waits until the erase ends.
  assign take = (op_r == OP_IDLE) && m_vld && !erase_go;

  fpes_merge #(.WA_W(WA_W)) u_merge (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .clr(clr),
    .wr(MEM_WR && mem_ok && MEM_RDY),
    .be(MEM_BE),
    .waddr(MEM_ADDR[ADDR_W-1:1]),
    .wdata(MEM_WDATA),
    .take(take),
    .vld(m_vld),
    .vaddr(m_addr),
    .vdata(m_data)
  );

  // Unlock sequence, page select and command decoding.
  always_comb begin
    lock_nxt = lock_r;
    psel_nxt = psel_r;
    if (PSEL_WR && lock_r == LK_LOCKED) begin
      psel_nxt = PSEL_DATA;
    end
    if (CMD_WR && op_r == OP_IDLE) begin
      unique case (lock_r)
        LK_LOCKED: begin
          lock_nxt = (CMD_DATA == `FPES_CMD_UNLOCK1) ? LK_HALF : LK_LOCKED;
        end
        LK_HALF: begin
          lock_nxt = (CMD_DATA == `FPES_CMD_UNLOCK2) ? LK_OPEN : LK_LOCKED;
        end
        LK_OPEN: begin
          if (CMD_DATA == `FPES_CMD_LOCK) begin
            lock_nxt = LK_LOCKED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      lock_r <= LK_LOCKED;
      psel_r <= 8'h00;
    end else begin
      lock_r <= lock_nxt;
      psel_r <= psel_nxt;
    end
  end

  // Operation sequencer: read old word, merge, program or erase.
  always_comb begin
    op_nxt = op_r;
    fa_nxt = fa_r;
    fd_nxt = fd_r;
    unique case (op_r)
      OP_IDLE: begin
        if (erase_go) begin
          fa_nxt = {psel_r[PG_W-1:0], {(PAGE_LSB-1){1'b0}}};
          fd_nxt = `FPES_ERASED_WORD;
          op_nxt = OP_ERASE;
        end else if (m_vld) begin
          fa_nxt = m_addr;
          fd_nxt = m_data;
          op_nxt = OP_READ;
        end
      end
      OP_READ: begin
        op_nxt = OP_MERGE;
      end
      OP_MERGE: begin
        fd_nxt = fd_r & FL_RDATA;
        op_nxt = OP_PROG;
      end
      OP_PROG, OP_ERASE: begin
        if (FL_DONE) begin
          op_nxt = OP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      op_r <= OP_IDLE;
      fa_r <= '0;
      fd_r <= 16'h0000;
    end else begin
      op_r <= op_nxt;
      fa_r <= fa_nxt;
      fd_r <= fd_nxt;
    end
  end

  assign FL_RD = (op_r == OP_READ);
  assign FL_PROG = (op_r == OP_PROG);
  assign FL_ERASE = (op_r == OP_ERASE);
  assign FL_ADDR = fa_r;
  assign FL_WDATA = fd_r;
  assign READ_WAIT = (op_r != OP_IDLE) || m_vld;
  assign IRQ_DEFER = (op_r != OP_IDLE) || m_vld;
  assign MEM_RDY = !m_vld && (op_r == OP_IDLE);
  assign UNLOCKED = (lock_r == LK_OPEN);
  assign PAGE_SEL = psel_r;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  prog_only_clears_a: assert property (
    op_r == OP_MERGE |=> (FL_WDATA & ~$past(FL_RDATA)) == 16'h0000)
    else $error("programming sets a bit");
  erase_data_ones_a: assert property (
    FL_ERASE |-> FL_WDATA == `FPES_ERASED_WORD)
    else $error("erase word not all ones");
  erase_page_sel_a: assert property (
    $rose(FL_ERASE) |-> FL_ADDR[WA_W-1:PAGE_LSB-1] == psel_r[PG_W-1:0]
      && FL_ADDR[PAGE_LSB-2:0] == '0)
    else $error("erase not on selected page");
  prog_stalls_read_a: assert property (
    FL_PROG |-> READ_WAIT && !MEM_RDY)
    else $error("reads not stalled in programming");
  busy_defers_irq_a: assert property (
    (FL_PROG || FL_ERASE) |-> IRQ_DEFER && READ_WAIT)
    else $error("interrupts not deferred");
  lock_cmd_a: assert property (
    CMD_WR && CMD_DATA == `FPES_CMD_LOCK && op_r == OP_IDLE
      |=> !UNLOCKED)
    else $error("lock command ignored");
  prot_refused_a: assert property (
    prot_hit(psel_r, SECT_PROT) && $stable(SECT_PROT) && $stable(psel_r)
      |-> !$rose(FL_PROG) && !$rose(FL_ERASE))
    else $error("protected page altered");
  outside_ignored_a: assert property (
    op_r == OP_IDLE && !m_vld && MEM_WR && !in_page |=> !m_vld)
    else $error("out of page write accepted");
  prog_path_a: assert property (
    take |=> FL_RD ##1 !FL_RD ##1 FL_PROG)
    else $error("program sequence broken");
  prog_flow_c: cover property (take ##[1:20] FL_DONE && FL_PROG);
  erase_flow_c: cover property ($rose(FL_ERASE) ##[1:50] $fell(FL_ERASE));
  unlock_c: cover property (lock_r == LK_HALF ##1 lock_r == LK_OPEN);
  byte_pair_c: cover property (MEM_WR && MEM_BE == 2'h1 ##[1:5]
    MEM_WR && MEM_BE == 2'h2 ##1 m_vld);
endmodule // fpes_seq

// file: fpes_flash_model.sv
// Behavioural flash array answering the sequencer's read, program and erase.
`timescale 1ns/100ps
module fpes_flash_model #(
  parameter int DLY = 6
) (
  input wire logic clk,
  input wire logic rd,
  input wire logic prog,
  input wire logic erase,
  input wire logic [15:0] addr,
  input wire fpes_pkg::fpes_word_t wdata,
  output fpes_pkg::fpes_word_t rdata,
  output logic done
);
  import fpes_pkg::*;
  fpes_word_t mem [65536];
  int cnt = 0;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  initial rdata = 16'h0000;
  initial done = 1'b0;
  function automatic fpes_word_t peek(input int a);
    return mem[a[15:0]];
  endfunction
  always @(posedge clk) begin
    rdata <= rd ? peek(addr) : ~rdata;
    done <= 1'b0;
    cnt <= ((prog || erase) && !done) ? cnt + 1 : 0;
    if ((prog || erase) && !done && cnt == DLY) begin
      done <= 1'b1;
      if (erase)
        for (int i = 0; i < 1024; i++) mem[{addr[15:10], i[9:0]}] = 16'hFFFF;
      else
        mem[addr] = wdata;
    end
  end
endmodule // fpes_flash_model

// file: tb_top.sv
// Self-checking testbench for the flash program and erase sequencer.
`timescale 1ns/100ps
module tb_top;
  import fpes_pkg::*;
  typedef struct packed {
    logic [16:0] a;
    logic [1:0] be;
    logic [15:0] d;
    logic bz;
    logic [15:0] ex;
  } fpes_row_t;
  fpes_row_t rows [5] = '{
    '{17'h01000, 2'h3, 16'h1234, 1'b1, 16'h1234},
    '{17'h01002, 2'h1, 16'h00AB, 1'b0, 16'hFFFF},
    '{17'h01002, 2'h2, 16'hCD00, 1'b1, 16'hCDAB},
    '{17'h01000, 2'h3, 16'hFF0F, 1'b1, 16'h1204},
    '{17'h01800, 2'h3, 16'h0000, 1'b0, 16'hFFFF}};
  logic CLK_SYS, RST_N, CMD_WR, PSEL_WR, MEM_WR, FL_DONE, MEM_RDY, FL_RD;
  logic FL_PROG, FL_ERASE, READ_WAIT, IRQ_DEFER, UNLOCKED, bz;
  logic [7:0] CMD_DATA, PSEL_DATA, SECT_PROT, PAGE_SEL;
  logic [16:0] MEM_ADDR;
  logic [1:0] MEM_BE;
  logic [15:0] FL_ADDR, fa, fw;
  fpes_word_t MEM_WDATA, FL_RDATA, FL_WDATA;
  int n_mismatch = 0;
  int checked = 0;
  int nr = 0;
  fpes_seq u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_WR(CMD_WR),
    .CMD_DATA(CMD_DATA), .PSEL_WR(PSEL_WR), .PSEL_DATA(PSEL_DATA),
    .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_BE(MEM_BE),
    .MEM_WDATA(MEM_WDATA), .SECT_PROT(SECT_PROT), .FL_RDATA(FL_RDATA),
    .FL_DONE(FL_DONE), .MEM_RDY(MEM_RDY), .FL_RD(FL_RD), .FL_PROG(FL_PROG),
    .FL_ERASE(FL_ERASE), .FL_ADDR(FL_ADDR), .FL_WDATA(FL_WDATA),
    .READ_WAIT(READ_WAIT), .IRQ_DEFER(IRQ_DEFER), .UNLOCKED(UNLOCKED),
    .PAGE_SEL(PAGE_SEL));
  fpes_flash_model u_fl (.clk(CLK_SYS), .rd(FL_RD), .prog(FL_PROG),
    .erase(FL_ERASE), .addr(FL_ADDR), .wdata(FL_WDATA), .rdata(FL_RDATA),
    .done(FL_DONE));
  always #12.5 CLK_SYS = ~CLK_SYS;
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] ex,
    input logic [16:0] got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic pulse(input logic c, input logic [7:0] b);
    @(posedge CLK_SYS);
    CMD_WR <= c;
    PSEL_WR <= !c;
    CMD_DATA <= b;
    PSEL_DATA <= b;
    @(posedge CLK_SYS);
    CMD_WR <= 1'b0;
    PSEL_WR <= 1'b0;
  endtask
  task automatic settle(output logic b);
    b = 1'b0;
    nr = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge CLK_SYS);
      if (FL_PROG === 1'b1) chk("stall", 1, READ_WAIT);
      if (FL_RD === 1'b1) nr++;
      if (FL_ERASE === 1'b1) fa = FL_ADDR;
      if (FL_ERASE === 1'b1) fw = FL_WDATA;
      if (READ_WAIT === 1'b1) begin
        b = 1'b1;
        chk("defer", 1, IRQ_DEFER);
      end
      else if (b) break;
    end
    chk("idle", 0, READ_WAIT);
  endtask
  task automatic wr(input logic [16:0] a, input logic [1:0] be,
    input logic [15:0] d, output logic b);
    @(posedge CLK_SYS);
    MEM_WR <= 1'b1;
    MEM_ADDR <= a;
    MEM_BE <= be;
    MEM_WDATA <= d;
    @(posedge CLK_SYS);
    MEM_WR <= 1'b0;
    settle(b);
  endtask
  task automatic unlock(input logic [7:0] pg);
    pulse(0, pg);
    pulse(1, 8'h73);
    pulse(1, 8'h8C);
  endtask
  initial begin
    #(25ns * 4000);
    n_mismatch++;
    stop_test;
  end
  initial begin
    {CLK_SYS, RST_N, CMD_WR, PSEL_WR, MEM_WR} = 5'h00;
    {CMD_DATA, PSEL_DATA, SECT_PROT, MEM_BE} = 26'h0;
    {MEM_ADDR, MEM_WDATA} = 33'h0;
    repeat (16) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(negedge CLK_SYS);
    chk("unl", 0, UNLOCKED);
    chk("rdy", 1, MEM_RDY);
    unlock(8'h02);
    @(negedge CLK_SYS);
    chk("unl", 1, UNLOCKED);
    chk("psel", 8'h02, PAGE_SEL);
    pulse(0, 8'h05);
    @(negedge CLK_SYS);
    chk("pfix", 8'h02, PAGE_SEL);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].be, rows[i].d, bz);
      chk("busy", rows[i].bz, bz);
      chk("rd", rows[i].bz, nr);
      chk("word", rows[i].ex, u_fl.peek(rows[i].a[16:1]));
    end
    pulse(1, 8'h95);
    settle(bz);
    chk("ebusy", 1, bz);
    chk("epage", 16'h0800, fa);
    chk("ewd", 16'hFFFF, fw);
    chk("ew0", 16'hFFFF, u_fl.peek(16'h0800));
    chk("ew1", 16'hFFFF, u_fl.peek(16'h0801));
    pulse(1, 8'h00);
    @(negedge CLK_SYS);
    chk("lock", 0, UNLOCKED);
    wr(17'h01000, 2'h3, 16'h0000, bz);
    chk("lbusy", 0, bz);
    @(posedge CLK_SYS);
    SECT_PROT <= 8'h02;
    unlock(8'h09);
    wr(17'h04800, 2'h3, 16'h0000, bz);
    chk("pbusy", 0, bz);
    pulse(1, 8'h95);
    settle(bz);
    chk("pers", 0, bz);
    pulse(1, 8'h00);
    unlock(8'h03);
    @(posedge CLK_SYS);
    MEM_WR <= 1'b1;
    MEM_ADDR <= 17'h01800;
    MEM_BE <= 2'h3;
    @(posedge CLK_SYS);
    MEM_WR <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b0;
    @(negedge CLK_SYS);
    chk("rprog", 1, FL_PROG);
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(negedge CLK_SYS);
    chk("rwait", 0, READ_WAIT);
    chk("rdefer", 0, IRQ_DEFER);
    chk("rrdy", 1, MEM_RDY);
    chk("rlock", 0, UNLOCKED);
    chk("rpsel", 8'h00, PAGE_SEL);
    chk("rword", 16'hFFFF, u_fl.peek(16'h0C00));
    wr(17'h01800, 2'h3, 16'h0000, bz);
    chk("rbusy", 0, bz);
    stop_test;
  end
endmodule // tb_top
